//--- uar_line_tx.sv
`timescale 1ns/1ps
module uar_line_tx (
	input wire logic core_clk,
	output logic rx_pin
);
	// line rests high, as its pull-up would hold it
	initial rx_pin = 1'b1;
	// start, data lsb first, stop, one idle bit; bit gb gets a one-cycle glitch at its centre
	task automatic send(input logic [8:0] d, input int nb, input int bc, input logic stop,
			input int gb);
		logic v;
		for (int i = 0; i < nb + 3; i++) begin
			v = (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : (i == nb + 1) ? stop : 1'b1;
			for (int c = 0; c < bc; c++) begin
				@(posedge core_clk);
				rx_pin <= (i == gb && c == bc / 2) ? ~v : v;
			end
		end
	endtask : send
	task automatic dip(input int n);
		@(posedge core_clk);
		rx_pin <= 1'b0;
		repeat (n) @(posedge core_clk);
		rx_pin <= 1'b1;
		repeat (64) @(posedge core_clk);
	endtask : dip
endmodule : uar_line_tx

//--- uar_pkg.sv
package uar_pkg;
	localparam int unsigned UAR_DATA_W = 9;
	localparam int unsigned UAR_DIV_W = 16;
	localparam int unsigned UAR_PRESC_W = 8;
	localparam int unsigned UAR_FIFO_DEPTH = 8;
	localparam int unsigned UAR_SMP_W = 5;
	// word length field codes
	localparam logic [1:0] UAR_WL_8 = 2'h0;
	localparam logic [1:0] UAR_WL_9 = 2'h1;
	localparam logic [1:0] UAR_WL_7 = 2'h2;
	localparam logic [3:0] UAR_BITS_7 = 4'h7;
	localparam logic [3:0] UAR_BITS_8 = 4'h8;
	localparam logic [3:0] UAR_BITS_9 = 4'h9;
	// oversample counts and sample positions within one bit
	localparam logic [4:0] UAR_OS16 = 5'h10;
	localparam logic [4:0] UAR_OS8 = 5'h08;
	localparam logic [4:0] UAR_IDLE_HIGH = 5'h03;
	localparam logic [4:0] UAR_S3 = 5'h03;
	localparam logic [4:0] UAR_S5 = 5'h05;
	localparam logic [4:0] UAR_S7 = 5'h07;
	localparam logic [4:0] UAR_S8 = 5'h08;
	localparam logic [4:0] UAR_S9 = 5'h09;
	localparam logic [4:0] UAR_S10 = 5'h0a;
	// entry layout: {idle, frame_err, noise, data}
	localparam int unsigned UAR_ENT_W = UAR_DATA_W + 3;
	localparam int unsigned UAR_E_NOISE = UAR_DATA_W;
	localparam int unsigned UAR_E_FE = UAR_DATA_W + 1;
	localparam int unsigned UAR_E_IDLE = UAR_DATA_W + 2;
	typedef enum logic [1:0] {UAR_IDLE, UAR_START, UAR_DATA, UAR_STOP} uar_state_t;
	// three samples -> {noise, bit}
	function automatic logic [1:0] uar_vote(input logic [2:0] s);
		logic maj;
		maj = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
		return {(s != 3'h0) && (s != 3'h7), maj};
	endfunction : uar_vote
endpackage : uar_pkg

//--- uar_receiver.sv
`timescale 1ns/1ps
// Operation
// - start bit needs high samples, a low sample, then further lows; same at 16x and 8x.
// - incomplete start pattern returns to idle silently, awaiting the next falling edge.
// - clean start needs samples 3,5,7 all low, and at 16x also 8,9,10; at 8x only 3,5,7 are voted.
// - two-of-three low in a group accepts start with noise; worse aborts silently.
// - data bits are assembled least significant bit first.
// - without queue, completed character moves to holding register and sets not-empty.
// - with queue, characters queue with error bits; reads return the oldest entry.
// - data interrupt follows not-empty flag, or queue flag with queue on, and its matching enable.
// - DMA mode requests while data is available; each DMA read pops one.
// - a data read pops one entry; flush request clears the not-empty flag.
// - a received break is handled as a framing error.
// - idle frame is not stored as a character; it sets the idle flag, plus interrupt if idle enable set.
// - without queue, overrun when flag still set; holding register is kept.
// - with queue, overrun when queue full; entries kept, new character lost.
// - overrun interrupts on error or data enable; overrun clear resets the flag.
// - kernel clock divided by programmable prescaler gives oversampling base rate.
// - oversample select picks 16x or 8x sampling per bit.
// - single-sample mode takes the centre sample and never flags noise.
// - majority of three samples, noise for any mixed pattern.
// - noise rises with the not-empty flag, or queue flag with queue on; data still delivered; interrupt only with DMA.
// - noise clear bit resets the noise flag.
// - smartcard, infrared and LIN modes force 16x oversampling.
// - word length field selects 7, 8 or 9 data bits.
// - framing error clear bit resets the framing error flag.
module uar_receiver
	import uar_pkg::*;
#(
	parameter int unsigned DEPTH = UAR_FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic rx_pin,
	input wire logic unit_on,
	input wire logic rx_on,
	input wire logic fifo_on,
	input wire logic rx_dma_on,
	input wire logic half_oversample_sel,
	input wire logic single_sample_sel,
	input wire logic special_mode,
	input wire logic [1:0] word_len,
	input wire logic [UAR_PRESC_W-1:0] clock_divider_reg,
	input wire logic [UAR_DIV_W-1:0] baud_div,
	input wire logic rx_avail_irq_on,
	input wire logic rx_queue_irq_on,
	input wire logic idle_irq_on,
	input wire logic error_irq_on,
	input wire logic data_read,
	input wire logic dma_ack,
	input wire logic rx_flush_request,
	input wire logic noise_clear_bit,
	input wire logic overrun_clear_bit,
	input wire logic frame_err_clear_bit,
	input wire logic idle_clear_bit,
	output logic [UAR_DATA_W-1:0] rx_data_holding,
	output logic rx_not_empty_flag,
	output logic rx_queue_avail_flag,
	output logic noise_flag,
	output logic frame_err_flag,
	output logic overrun_flag,
	output logic idle_flag,
	output logic dma_req,
	output logic irq
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s_prev;
		logic [UAR_PRESC_W-1:0] pre_cnt;
		logic [UAR_DIV_W-1:0] baud_cnt;
		uar_state_t state;
		logic [UAR_SMP_W-1:0] smp;
		logic [UAR_SMP_W-1:0] high_run;
		logic [2:0] grp;
		logic [3:0] bit_idx;
		logic [UAR_DATA_W-1:0] shift;
		logic all_ones;
		logic noisy;
		logic [UAR_DATA_W-1:0] hold;
		logic hold_noise;
		logic hold_fe;
		logic not_empty;
		logic queue_avail;
		logic noise;
		logic fe;
		logic ovr;
		logic idle;
		logic dma;
		logic irq;
	} uar_st_t;
	uar_st_t st;
	uar_st_t next_st;

	logic [UAR_ENT_W-1:0] q_head;
	logic q_full;
	logic q_empty;
	logic q_push;
	logic q_pop;
	logic [UAR_ENT_W-1:0] q_in;

	logic tick;
	logic baud_tick;
	logic [UAR_SMP_W-1:0] os_n;
	logic [3:0] nbits;
	logic [1:0] v;
	logic cur;
	logic frame_done;
	logic fe_now;
	logic idle_now;
	logic [UAR_DATA_W-1:0] char_data;
	logic pop_any;

	////////////////////////////////////////////////////////////////////////
	// queue of received entries
	uar_rx_queue #(.WIDTH(UAR_ENT_W), .DEPTH(DEPTH)) u_queue (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.flush(rx_flush_request || !fifo_on),
		.push(q_push),
		.push_data(q_in),
		.pop(q_pop),
		.head(q_head),
		.full(q_full),
		.empty(q_empty)
	);

	////////////////////////////////////////////////////////////////////////
	// sample-rate timing
	always_comb begin
		// a divider of zero gives a tick on every clock
		tick = st.pre_cnt == '0;
		baud_tick = tick && (st.baud_cnt == '0);
		os_n = (half_oversample_sel && !special_mode) ? UAR_OS8 : UAR_OS16;
		unique case (word_len)
			UAR_WL_9: nbits = UAR_BITS_9;
			UAR_WL_7: nbits = UAR_BITS_7;
			default: nbits = UAR_BITS_8;
		endcase
		cur = st.s2;
		v = uar_vote({st.grp[1:0], cur});
		if (single_sample_sel) begin
			v = {1'b0, st.grp[0]};
		end
		pop_any = data_read || (rx_dma_on && dma_ack);
	end

	////////////////////////////////////////////////////////////////////////
	// receive engine and flags
	always_comb begin
		next_st = st;
		// clears first so a same-cycle event wins
		if (noise_clear_bit) next_st.noise = 1'b0;
		if (frame_err_clear_bit) next_st.fe = 1'b0;
		if (overrun_clear_bit) next_st.ovr = 1'b0;
		if (idle_clear_bit) next_st.idle = 1'b0;
		frame_done = 1'b0;
		fe_now = 1'b0;
		idle_now = 1'b0;
		char_data = st.shift >> (UAR_DATA_W - 32'(nbits));
		q_push = 1'b0;
		q_pop = 1'b0;
		q_in = '0;
		// two flops take the line into this clock before anything reads it
		next_st.s1 = rx_pin;
		next_st.s2 = st.s1;
		next_st.pre_cnt = tick ? clock_divider_reg : st.pre_cnt - 1'b1;
		if (tick) begin
			next_st.baud_cnt = (st.baud_cnt == '0) ?
				UAR_DIV_W'((baud_div >> (os_n == UAR_OS8 ? 3 : 4)) - 1'b1) :
				st.baud_cnt - 1'b1;
		end
		if (baud_tick) begin
			next_st.s_prev = cur;
			next_st.smp = st.smp + 1'b1;
			unique case (st.state)
				UAR_IDLE: begin
					// three high samples must precede the falling one
					next_st.smp = '0;
					if (cur) begin
						if (st.high_run != UAR_IDLE_HIGH) begin
							next_st.high_run = st.high_run + 1'b1;
						end
					end else if (st.high_run == UAR_IDLE_HIGH) begin
						// the falling sample is sample one, so the next tick is sample two
						next_st.state = UAR_START;
						next_st.smp = 5'h02;
						next_st.grp = '0;
						next_st.noisy = 1'b0;
						next_st.high_run = '0;
					end else begin
						next_st.high_run = '0;
					end
				end
				UAR_START: begin
					// samples taken at 3,5,7 then 8,9,10 after the falling edge
					if (st.smp == UAR_S3 || st.smp == UAR_S5 || st.smp == UAR_S8
						|| st.smp == UAR_S9) begin
						next_st.grp = {st.grp[1:0], cur};
					end
					if (st.smp == UAR_S7 || st.smp == UAR_S10) begin
						next_st.grp = '0;
						unique case ({st.grp[1:0], cur})
							3'h0: ;
							3'h1, 3'h2, 3'h4: next_st.noisy = !single_sample_sel;
							default: begin
								next_st.state = UAR_IDLE;
								next_st.high_run = '0;
							end
						endcase
					end
					// at 8x the start bit ends at sample 8, so only the first group is voted
					if (st.smp == os_n) begin
						next_st.state = UAR_DATA;
						next_st.smp = '0;
						next_st.bit_idx = '0;
						next_st.all_ones = 1'b1;
					end
				end
				UAR_DATA, UAR_STOP: begin
					if (st.smp == (os_n >> 1) - 1'b1 || st.smp == (os_n >> 1)) begin
						next_st.grp = {st.grp[1:0], cur};
					end
					if (st.smp == (os_n >> 1) + 1'b1) begin
						next_st.noisy = st.noisy | v[1];
						next_st.all_ones = st.all_ones & v[0];
						if (st.state == UAR_DATA) begin
							next_st.shift = {v[0], st.shift[UAR_DATA_W-1:1]};
						end else begin
							frame_done = 1'b1;
							fe_now = !v[0];
							idle_now = st.all_ones && v[0] && !st.noisy;
						end
					end
					if (st.smp == os_n - 1'b1) begin
						next_st.smp = '0;
						next_st.bit_idx = st.bit_idx + 1'b1;
						if (st.bit_idx == nbits - 1'b1) begin
							next_st.state = UAR_STOP;
						end
					end
					if (frame_done) begin
						next_st.state = UAR_IDLE;
						next_st.high_run = fe_now ? '0 : 5'h01;
					end
				end
				default: next_st.state = UAR_IDLE;
			endcase
		end
		// delivery of a finished frame; a frame with no noise before its stop bit, and all data bits and the stop bit high, counts as idle
		if (idle_now) begin
			next_st.idle = 1'b1;
		end
		if (fifo_on) begin
			q_pop = pop_any;
			// a pop in the same cycle frees a slot, so a full queue still takes the frame
			if (frame_done && !idle_now) begin
				if (q_full && !q_pop) begin
					next_st.ovr = 1'b1;
				end else begin
					q_push = 1'b1;
					q_in = {1'b0, fe_now, next_st.noisy, char_data};
				end
			end
		end else begin
			if (pop_any || rx_flush_request) begin
				next_st.not_empty = 1'b0;
			end
			if (frame_done && !idle_now) begin
				if (st.not_empty && !pop_any) begin
					next_st.ovr = 1'b1;
				end else begin
					next_st.hold = char_data;
					next_st.hold_noise = next_st.noisy;
					next_st.hold_fe = fe_now;
					next_st.not_empty = 1'b1;
				end
			end
		end
		// error bits follow only a frame that was stored, never one lost to overrun
		if (frame_done && !idle_now
			&& (fifo_on ? q_push : !(st.not_empty && !pop_any))) begin
			next_st.noise = next_st.noise | next_st.noisy;
			next_st.fe = next_st.fe | fe_now;
		end
		if (st.ovr && !overrun_clear_bit) next_st.ovr = 1'b1;
		// flush drops the flag at once, or a cycle later if a pop of a queued entry comes with it; popping the last entry clears it a cycle later
		next_st.queue_avail = fifo_on && !rx_flush_request &&
			!(q_empty && !q_push) && !(q_pop && !q_push && q_empty);
		if (fifo_on && !q_empty && q_pop && !q_push) begin
			next_st.queue_avail = 1'b1;
		end
		next_st.dma = rx_dma_on && (fifo_on ? next_st.queue_avail : next_st.not_empty);
		next_st.irq = (!fifo_on && rx_avail_irq_on && next_st.not_empty)
			|| (fifo_on && rx_queue_irq_on && next_st.queue_avail)
			|| (idle_irq_on && next_st.idle)
			|| (next_st.ovr && (error_irq_on || rx_avail_irq_on || rx_queue_irq_on))
			|| (rx_dma_on && error_irq_on && (next_st.noise || next_st.fe));
		if (!unit_on || !rx_on) begin
			next_st.state = UAR_IDLE;
			next_st.high_run = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs; in queue mode the head stays visible in the holding register
	// the head trails a pop by one cycle, like the queue flag
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_data_holding <= '0;
			rx_not_empty_flag <= 1'b0;
			rx_queue_avail_flag <= 1'b0;
			noise_flag <= 1'b0;
			frame_err_flag <= 1'b0;
			overrun_flag <= 1'b0;
			idle_flag <= 1'b0;
			dma_req <= 1'b0;
			irq <= 1'b0;
		end else if (ce) begin
			rx_data_holding <= fifo_on ? q_head[UAR_DATA_W-1:0] : next_st.hold;
			rx_not_empty_flag <= next_st.not_empty;
			rx_queue_avail_flag <= next_st.queue_avail;
			noise_flag <= next_st.noise;
			frame_err_flag <= next_st.fe;
			overrun_flag <= next_st.ovr;
			idle_flag <= next_st.idle;
			dma_req <= next_st.dma;
			irq <= next_st.irq;
		end
	end
endmodule : uar_receiver

//--- uar_receiver_asserts.sv
`timescale 1ns/1ps
module uar_receiver_asserts
	import uar_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic fifo_on,
	input wire logic rx_dma_on,
	input wire logic single_sample_sel,
	input wire logic rx_avail_irq_on,
	input wire logic error_irq_on,
	input wire logic data_read,
	input wire logic rx_flush_request,
	input wire logic noise_clear_bit,
	input wire logic overrun_clear_bit,
	input wire logic frame_err_clear_bit,
	input wire logic [UAR_DATA_W-1:0] rx_data_holding,
	input wire logic rx_not_empty_flag,
	input wire logic rx_queue_avail_flag,
	input wire logic noise_flag,
	input wire logic frame_err_flag,
	input wire logic overrun_flag,
	input wire logic dma_req,
	input wire logic irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic any_avail;
	assign any_avail = rx_not_empty_flag || rx_queue_avail_flag;
	////////////////////////////////////////////////////////////////////////////////
	property p_read_pops; ce && data_read && !fifo_on |=> !rx_not_empty_flag; endproperty
	a_read_pops: assert property (p_read_pops) else $error("read left flag set");
	property p_flush; ce && rx_flush_request |=> !any_avail; endproperty
	a_flush: assert property (p_flush) else $error("flush left data");
	property p_irq_data;
		ce && rx_not_empty_flag && rx_avail_irq_on && $past(rx_avail_irq_on) && !fifo_on |-> irq;
	endproperty
	a_irq_data: assert property (p_irq_data) else $error("no data irq");
	property p_irq_err; ce && overrun_flag && error_irq_on && $past(error_irq_on) |-> irq; endproperty
	a_irq_err: assert property (p_irq_err) else $error("no overrun irq");
	property p_noise_with_data; $rose(noise_flag) |-> any_avail; endproperty
	a_noise_with_data: assert property (p_noise_with_data) else $error("noise alone");
	property p_fe_with_data; $rose(frame_err_flag) |-> any_avail; endproperty
	a_fe_with_data: assert property (p_fe_with_data) else $error("frame error alone");
	property p_single_quiet; single_sample_sel && $past(single_sample_sel, 2) |-> !$rose(noise_flag);
	endproperty
	a_single_quiet: assert property (p_single_quiet) else $error("noise in single mode");
	// holding must survive the character that overran it
	property p_ovr_keeps;
		$rose(overrun_flag) && !fifo_on && !$past(data_read) |-> $stable(rx_data_holding);
	endproperty
	a_ovr_keeps: assert property (p_ovr_keeps) else $error("holding lost");
	property p_ovr_rise; $rose(overrun_flag) |-> any_avail; endproperty
	a_ovr_rise: assert property (p_ovr_rise) else $error("overrun with no data");
	property p_nz_clr; ce && noise_clear_bit |=> !noise_flag; endproperty
	a_nz_clr: assert property (p_nz_clr) else $error("noise not cleared");
	property p_fe_clr; ce && frame_err_clear_bit |=> !frame_err_flag; endproperty
	a_fe_clr: assert property (p_fe_clr) else $error("frame error not cleared");
	property p_ovr_clr; ce && overrun_clear_bit |=> !overrun_flag; endproperty
	a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared");
	property p_dma;
		ce && rx_dma_on && $past(rx_dma_on) && rx_not_empty_flag && !fifo_on |-> dma_req;
	endproperty
	a_dma: assert property (p_dma) else $error("no dma request");
endmodule : uar_receiver_asserts

bind uar_receiver uar_receiver_asserts i_chk (
	.core_clk(core_clk), .rst(rst), .ce(ce), .fifo_on(fifo_on), .rx_dma_on(rx_dma_on),
	.single_sample_sel(single_sample_sel), .rx_avail_irq_on(rx_avail_irq_on),
	.error_irq_on(error_irq_on), .data_read(data_read), .rx_flush_request(rx_flush_request),
	.noise_clear_bit(noise_clear_bit), .overrun_clear_bit(overrun_clear_bit),
	.frame_err_clear_bit(frame_err_clear_bit), .rx_data_holding(rx_data_holding),
	.rx_not_empty_flag(rx_not_empty_flag), .rx_queue_avail_flag(rx_queue_avail_flag),
	.noise_flag(noise_flag), .frame_err_flag(frame_err_flag), .overrun_flag(overrun_flag),
	.dma_req(dma_req), .irq(irq));

//--- uar_receiver_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
	$display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module uar_receiver_tb
	import uar_pkg::*;
;
	localparam logic [6:0] RD = 7'h40, DA = 7'h20, FL = 7'h10, NC = 7'h08, OC = 7'h04, FC = 7'h02;
	localparam logic [6:0] IC = 7'h01;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic on = 1'b1, fifo_on = 1'b0, dma_on = 1'b0, h8 = 1'b0, one = 1'b0;
	logic av_ie = 1'b1, er_ie = 1'b0;
	logic sm = 1'b0, idie = 1'b0;
	logic [1:0] wl = UAR_WL_8;
	logic [7:0] presc = 8'h00;
	logic [6:0] pul = 7'h00;
	logic rx_pin, ne, qa, nf, fe, ov, dq, irq, idf;
	logic [8:0] hold;
	int errors = 0, checks_done = 0;
	uar_line_tx i_tx (.core_clk(core_clk), .rx_pin(rx_pin));
	uar_receiver #(.DEPTH(2)) i_dut (
		.core_clk(core_clk), .rst(rst), .ce(1'b1), .rx_pin(rx_pin), .unit_on(on), .rx_on(on),
		.fifo_on(fifo_on), .rx_dma_on(dma_on), .half_oversample_sel(h8),
		.single_sample_sel(one), .special_mode(sm), .word_len(wl), .clock_divider_reg(presc),
		.baud_div(16'h0010), .rx_avail_irq_on(av_ie), .rx_queue_irq_on(av_ie),
		.idle_irq_on(idie), .error_irq_on(er_ie), .data_read(pul[6]), .dma_ack(pul[5]),
		.rx_flush_request(pul[4]), .noise_clear_bit(pul[3]), .overrun_clear_bit(pul[2]),
		.frame_err_clear_bit(pul[1]), .idle_clear_bit(pul[0]), .rx_data_holding(hold),
		.rx_not_empty_flag(ne), .rx_queue_avail_flag(qa), .noise_flag(nf), .frame_err_flag(fe),
		.overrun_flag(ov), .idle_flag(idf), .dma_req(dq), .irq(irq));
	always #12.5 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic pulse(input logic [6:0] m);
		@(posedge core_clk);
		pul <= m;
		@(posedge core_clk);
		pul <= 7'h00;
		// queue head and flag settle one edge after the pop
		@(posedge core_clk);
		#1;
	endtask : pulse
	task automatic rx(input logic [8:0] d, input int nb, input logic stop, input int gb);
		i_tx.send(d, nb, 16 * (presc + 1), stop, gb);
		#1;
	endtask : rx
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_words();
		logic [1:0] wls[3] = '{UAR_WL_8, UAR_WL_9, UAR_WL_7};
		int nbs[3] = '{8, 9, 7};
		logic [8:0] ds[3] = '{9'h0a5, 9'h1c3, 9'h035};
		for (int k = 0; k < 9; k++) begin
			@(posedge core_clk);
			wl <= wls[k % 3];
			h8 <= (k >= 3);
			sm <= (k >= 6);
			rx(ds[k % 3], nbs[k % 3], 1'b1, -1);
			`CHK("data", ds[k % 3], hold)
			`CHK("not_empty", 1'b1, ne)
			`CHK("irq", 1'b1, irq)
			pulse(RD);
			`CHK("not_empty_rd", 1'b0, ne)
		end
		@(posedge core_clk);
		wl <= UAR_WL_8;
		h8 <= 1'b0;
		sm <= 1'b0;
	endtask : t_words
	task automatic t_overrun();
		@(posedge core_clk);
		av_ie <= 1'b0;
		er_ie <= 1'b1;
		rx(9'h011, 8, 1'b1, -1);
		rx(9'h022, 8, 1'b1, -1);
		`CHK("ovr", 1'b1, ov)
		`CHK("ovr_hold", 9'h011, hold)
		`CHK("ovr_irq", 1'b1, irq)
		pulse(OC | RD);
		`CHK("ovr_clr", 1'b0, ov)
	endtask : t_overrun
	// queue depth is two here, so the third character overruns
	task automatic t_fifo();
		@(posedge core_clk);
		fifo_on <= 1'b1;
		rx(9'h0a1, 8, 1'b1, -1);
		rx(9'h0b2, 8, 1'b1, -1);
		rx(9'h0c3, 8, 1'b1, -1);
		`CHK("q_ovr", 1'b1, ov)
		`CHK("q_head", 9'h0a1, hold)
		pulse(RD);
		`CHK("q_head2", 9'h0b2, hold)
		pulse(RD);
		`CHK("q_empty", 1'b0, qa)
		rx(9'h0d4, 8, 1'b1, -1);
		`CHK("q_avail", 1'b1, qa)
		pulse(FL | OC);
		`CHK("q_flush", 1'b0, qa)
		@(posedge core_clk);
		fifo_on <= 1'b0;
	endtask : t_fifo
	task automatic t_noise();
		rx(9'h05a, 8, 1'b1, 2);
		`CHK("nz", 1'b1, nf)
		`CHK("nz_data", 9'h05a, hold)
		`CHK("nz_ne", 1'b1, ne)
		pulse(NC | RD);
		`CHK("nz_clr", 1'b0, nf)
		@(posedge core_clk);
		one <= 1'b1;
		rx(9'h05a, 8, 1'b1, 2);
		`CHK("one_nz", 1'b0, nf)
		`CHK("one_data", 9'h058, hold)
		pulse(RD);
		@(posedge core_clk);
		one <= 1'b0;
	endtask : t_noise
	task automatic t_idle();
		@(posedge core_clk);
		idie <= 1'b1;
		rx(9'h0ff, 8, 1'b1, -1);
		`CHK("idle", 1'b1, idf)
		`CHK("idle_irq", 1'b1, irq)
		`CHK("idle_ne", 1'b0, ne)
		pulse(IC);
		`CHK("idle_clr", 1'b0, idf)
		`CHK("idle_irq_clr", 1'b0, irq)
		@(posedge core_clk);
		idie <= 1'b0;
	endtask : t_idle
	task automatic t_misc();
		i_tx.dip(3);
		`CHK("abort_ne", 1'b0, ne)
		`CHK("abort_nz", 1'b0, nf)
		rx(9'h000, 8, 1'b0, -1);
		`CHK("brk_fe", 1'b1, fe)
		`CHK("brk_ne", 1'b1, ne)
		pulse(FC | RD);
		`CHK("fe_clr", 1'b0, fe)
		@(posedge core_clk);
		dma_on <= 1'b1;
		rx(9'h03c, 8, 1'b1, -1);
		`CHK("dma_req", 1'b1, dq)
		pulse(DA);
		`CHK("dma_done", 1'b0, dq)
		`CHK("dma_ne", 1'b0, ne)
		@(posedge core_clk);
		dma_on <= 1'b0;
		presc <= 8'h01;
		@(posedge core_clk);
		rx(9'h069, 8, 1'b1, -1);
		`CHK("presc_data", 9'h069, hold)
		pulse(RD);
		@(posedge core_clk);
		presc <= 8'h00;
	endtask : t_misc
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		t_misc();
		t_words();
		t_overrun();
		t_fifo();
		t_noise();
		t_idle();
		end_of_test();
	end
	initial begin
		repeat (40000) @(posedge core_clk);
		errors++;
		end_of_test();
	end
endmodule : uar_receiver_tb

//--- uar_rx_queue.sv
`timescale 1ns/1ps
module uar_rx_queue
	import uar_pkg::*;
#(
	parameter int unsigned WIDTH = UAR_ENT_W,
	parameter int unsigned DEPTH = UAR_FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic flush,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] head,
	output logic full,
	output logic empty
);
	localparam int unsigned AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} uar_q_t;
	uar_q_t st;
	uar_q_t next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic do_push;
	logic do_pop;

	assign full = st.cnt == (AW+1)'(DEPTH);
	assign empty = st.cnt == '0;
	assign head = mem[st.rd];
	// a pop in the same cycle frees the oldest slot, so a full queue still accepts
	assign do_push = push && (!full || do_pop);
	assign do_pop = pop && !empty;

	always_comb begin
		next_st = st;
		if (flush) begin
			next_st = '0;
		end else begin
			if (do_push) begin
				next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
			end
			if (do_pop) begin
				next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
			end
			next_st.cnt = st.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
			if (do_push && !flush) begin
				mem[st.wr] <= push_data;
			end
		end
	end
endmodule : uar_rx_queue
